// >>> shared/nvmc_params.svh
// Constants for the nonvolatile memory self-program controller
`ifndef NVMC_PARAMS_SVH
`define NVMC_PARAMS_SVH

// Register offsets on the software port
`define NVMC_OFS_ADDR_LO  3'h0
`define NVMC_OFS_ADDR_HI  3'h1
`define NVMC_OFS_DATA_LO  3'h2
`define NVMC_OFS_DATA_HI  3'h3
`define NVMC_OFS_CTRL     3'h4
`define NVMC_OFS_KEY      3'h5
`define NVMC_OFS_IRQ_FLG  3'h6
`define NVMC_OFS_IRQ_ENA  3'h7

// Control register field positions
`define NVMC_BIT_FLASH    7
`define NVMC_BIT_CFG      6
`define NVMC_BIT_LATCH    5
`define NVMC_BIT_ERASE    4
`define NVMC_BIT_ERR      3
`define NVMC_BIT_PROG_EN  2
`define NVMC_BIT_WR       1
`define NVMC_BIT_RD       0

// Reset values and fixed patterns
`define NVMC_RST_BYTE     8'h00
`define NVMC_ADDR_HI_PAD  1'b1
`define NVMC_KEY_FIRST    8'h55
`define NVMC_KEY_SECOND   8'hAA

// Accessible configuration addresses
`define NVMC_CFG_UID_LAST 15'h0003
`define NVMC_CFG_ID_WORD  15'h0006
`define NVMC_CFG_WORD_LO  15'h0007
`define NVMC_CFG_WORD_HI  15'h0008

`endif

// >>> shared/nvmc_pkg.sv
// Types for the nonvolatile memory self-program controller
`default_nettype none
package nvmc_pkg;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        NVMC_ST_IDLE  = 4'b0001,
        NVMC_ST_READ  = 4'b0010,
        NVMC_ST_LATCH = 4'b0100,
        NVMC_ST_BUSY  = 4'b1000
    } nvmc_state_type;

    // Unlock key tracker, one-hot
    typedef enum logic [2:0] {
        NVMC_KEY_NONE  = 3'b001,
        NVMC_KEY_HALF  = 3'b010,
        NVMC_KEY_OPEN  = 3'b100
    } nvmc_key_type;

    // Command to the arrays
    typedef enum logic [2:0] {
        NVMC_CMD_NONE  = 3'h0,
        NVMC_CMD_READ  = 3'h1,
        NVMC_CMD_LATCH = 3'h2,
        NVMC_CMD_PROG  = 3'h3,
        NVMC_CMD_ERASE = 3'h4,
        NVMC_CMD_EEWR  = 3'h5
    } nvmc_cmd_type;

    // Software register port
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } nvmc_bus_type;

    // Request toward the arrays
    typedef struct packed {
        logic         req;
        nvmc_cmd_type cmd;
        logic         flash;
        logic         cfg;
        logic [14:0]  addr;
        logic [13:0]  wdata;
    } nvmc_mem_type;

    // Control register contents
    typedef struct packed {
        logic flash;
        logic cfg;
        logic latch_only;
        logic erase;
        logic err;
        logic prog_en;
        logic wr;
        logic rd;
    } nvmc_ctrl_type;

endpackage
`default_nettype wire

// >>> logic/nvmc_ctrl.sv
// Nonvolatile memory self-program controller: registers, unlock and sequencer
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "nvmc_params.svh"

////////////////////////////////////////////////////////////////////////////
// Register map on the software port
//   0  address low, all eight bits stored
//   1  address high, seven bits stored, top bit always reads one
//   2  data low, bits 7:0 of the data pair
//   3  data high, bits 13:8 of the data pair, top two bits read zero
//   4  control: space selects, latch-only, erase, error, enable, strobes
//   5  unlock key, write-only, never stored, reads zero
//   6  done flag in bit 0, set by hardware, cleared by software
//   7  done interrupt enable in bit 0
//
// Control bits
//   7  flash select, one for program flash
//   6  config select, one for config, user ID and device ID words
//   5  latch-only, flash and config space only
//   4  erase select, flash and config space only, cleared after erase
//   3  error flag, software may clear, a hardware set wins
//   2  program enable, zero blocks every write and erase
//   1  write strobe, set only, cleared when the array finishes or the latch cycle ends
//   0  read strobe, set only, cleared after one array cycle
//
// Unlock
//   Key 55h then AAh, then the strobe write as the next bus access.
//   Idle cycles between them keep the key; any other access drops it.
//   A strobe that meets no key, no enable or a read-only config word
//   only raises the error flag and starts nothing.
//
// Sequencer
//   Idle to read: one cycle, array data captured, read strobe drops.
//   Idle to latch: one cycle, latches loaded, stall for that cycle.
//   Idle to busy: until the array reports done or abort.
//   Busy ends with strobe and stall low and the done flag set;
//   an abort sets the error flag instead of the done flag.
//   Erase also clears the erase select when it completes.
//
// Memory side
//   A request is a one-cycle pulse; command, space selects, address
//   and data stand beside it, and the command holds until the end.
//   Commands: none, read, latch load, program, erase, EEPROM write.
//   Done and abort count only while a timed command runs.
//
// Interrupt
//   The done flag is sticky; the request level is flag and enable,
//   registered from their next values, so it changes in the same cycle as either one.
//
// Hazards and limits
//   The array must answer a read in the request cycle; a slower array
//   needs a wait state that this block does not provide.
//   A strobe written while a timed write runs is dropped without an
//   error: the strobe bit already reads one, so software sees it busy.
//   A strobe during a read cycle is dropped as well, but still uses
//   up the key, so software retries with a fresh unlock.
//   Dropping the two instructions after the strobe is left to the
//   processor; this block only raises the stall level.
//   Control writes while busy still change the space selects seen by
//   the arrays, so software must leave them alone until idle.
//   Latch-only loads need the unlock too, and raise no done flag.
//   The error flag is not set by an accepted strobe, only by a refused
//   one or by an abort, so a clean write leaves it at zero.
////////////////////////////////////////////////////////////////////////////

module nvmc_ctrl
    import nvmc_pkg::*;
(
    input  wire logic         clk_sys_i,
    input  wire logic         reset_i,
    input  wire nvmc_bus_type bus_i,
    output var  logic [7:0]   bus_rdata_o,
    output var  nvmc_mem_type mem_o,
    input  wire logic [13:0]  mem_rdata_i,
    input  wire logic         mem_done_i,
    input  wire logic         mem_abort_i,
    output var  logic         cpu_stall_o,
    output var  logic         nvm_irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // State record
    // One record for all state, so reset and update cannot drift apart
    // and the outputs are plain copies of its fields
    typedef struct packed {
        nvmc_state_type st;
        nvmc_key_type   key;
        nvmc_ctrl_type  ctrl;
        logic [7:0]     addr_lo;
        logic [6:0]     addr_hi;
        logic [13:0]    data;
        logic           done_flag;
        logic           done_ie;
        logic [7:0]     rdata;
        nvmc_mem_type   mem;
        logic           stall;
        logic           irq;
    } nvmc_regs_type;

    nvmc_regs_type r_r;
    nvmc_regs_type r_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Decoded helpers
    logic        wr_ctrl;
    logic        wr_key;
    logic        is_eeprom;
    logic [14:0] full_addr;
    logic        cfg_readable;
    logic        cfg_writable;
    logic        wr_request;
    logic        rd_request;
    logic        wr_allowed;
    logic        op_done;
    logic        op_abort;

    // Bus strobes toward the control and key registers
    // Only these two offsets do more than a plain store
    always_comb begin
        wr_ctrl = bus_i.wr && (bus_i.addr == `NVMC_OFS_CTRL);
        wr_key  = bus_i.wr && (bus_i.addr == `NVMC_OFS_KEY);
    end

    // Target space and address checks
    // Config space decodes the whole 15-bit address; the config
    // select itself marks the region
    always_comb begin
        is_eeprom    = !r_r.ctrl.cfg && !r_r.ctrl.flash;
        full_addr    = {r_r.addr_hi, r_r.addr_lo};
        cfg_writable = (full_addr <= `NVMC_CFG_UID_LAST);
        cfg_readable = cfg_writable
                    || (full_addr == `NVMC_CFG_ID_WORD)
                    || (full_addr == `NVMC_CFG_WORD_LO)
                    || (full_addr == `NVMC_CFG_WORD_HI);
    end

    // Strobe requests; a strobe already set is not a new request
    // So a busy sequencer never sees a second start; read yields
    // to write when both are written at once
    always_comb begin
        wr_request = wr_ctrl && bus_i.wdata[`NVMC_BIT_WR] && !r_r.ctrl.wr;
        rd_request = wr_ctrl && bus_i.wdata[`NVMC_BIT_RD] && !r_r.ctrl.rd
                  && !bus_i.wdata[`NVMC_BIT_WR]
                  && r_r.st == NVMC_ST_IDLE;
    end

    // A write needs the key, the enable and a writable target
    // One place, so refusal and error flag share one cause
    always_comb begin
        wr_allowed = (r_r.key == NVMC_KEY_OPEN)
                  && r_r.ctrl.prog_en
                  && (r_r.st == NVMC_ST_IDLE)
                  && (!r_r.ctrl.cfg || cfg_writable);
    end

    // Array handshake while busy
    // Done wins over abort when both come at once
    always_comb begin
        op_done  = (r_r.st == NVMC_ST_BUSY) && mem_done_i;
        op_abort = (r_r.st == NVMC_ST_BUSY) && mem_abort_i && !mem_done_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    // Later assignments win: hardware sets and clears come after the
    // software writes so that the hardware event has priority
    always_comb begin
        r_nxt         = r_r;
        r_nxt.mem.req = 1'b0;
        r_nxt.rdata   = `NVMC_RST_BYTE;

        // Key tracker: any access other than the second key breaks it
        // Idle cycles leave it where it is; a wrong byte or any other
        // access starts it over
        if (wr_key) begin
            if (bus_i.wdata == `NVMC_KEY_FIRST) begin
                r_nxt.key = NVMC_KEY_HALF;
            end else if (bus_i.wdata == `NVMC_KEY_SECOND
                         && r_r.key == NVMC_KEY_HALF) begin
                r_nxt.key = NVMC_KEY_OPEN;
            end else begin
                r_nxt.key = NVMC_KEY_NONE;
            end
        end else if (bus_i.wr || bus_i.rd) begin
            r_nxt.key = NVMC_KEY_NONE;
        end

        // Plain register writes
        // Strobe bits left out; only the strobe logic sets them
        if (bus_i.wr) begin
            if (bus_i.addr == `NVMC_OFS_ADDR_LO) begin
                r_nxt.addr_lo = bus_i.wdata;
            end else if (bus_i.addr == `NVMC_OFS_ADDR_HI) begin
                r_nxt.addr_hi = bus_i.wdata[6:0];
            end else if (bus_i.addr == `NVMC_OFS_DATA_LO) begin
                r_nxt.data[7:0] = bus_i.wdata;
            end else if (bus_i.addr == `NVMC_OFS_DATA_HI) begin
                r_nxt.data[13:8] = bus_i.wdata[5:0];
            end else if (bus_i.addr == `NVMC_OFS_CTRL) begin
                r_nxt.ctrl.flash = bus_i.wdata[`NVMC_BIT_FLASH];
                r_nxt.ctrl.cfg   = bus_i.wdata[`NVMC_BIT_CFG];
                r_nxt.ctrl.latch_only = bus_i.wdata[`NVMC_BIT_LATCH];
                r_nxt.ctrl.erase = bus_i.wdata[`NVMC_BIT_ERASE];
                r_nxt.ctrl.err   = bus_i.wdata[`NVMC_BIT_ERR];
                r_nxt.ctrl.prog_en = bus_i.wdata[`NVMC_BIT_PROG_EN];
            end else if (bus_i.addr == `NVMC_OFS_IRQ_FLG) begin
                r_nxt.done_flag = bus_i.wdata[0];
            end else if (bus_i.addr == `NVMC_OFS_IRQ_ENA) begin
                r_nxt.done_ie = bus_i.wdata[0];
            end
        end

        // Read data, one cycle after the read strobe
        // Zero in every other cycle, so nothing stale stays on the
        // read port
        if (bus_i.rd) begin
            if (bus_i.addr == `NVMC_OFS_ADDR_LO) begin
                r_nxt.rdata = r_r.addr_lo;
            end else if (bus_i.addr == `NVMC_OFS_ADDR_HI) begin
                r_nxt.rdata = {`NVMC_ADDR_HI_PAD, r_r.addr_hi};
            end else if (bus_i.addr == `NVMC_OFS_DATA_LO) begin
                r_nxt.rdata = r_r.data[7:0];
            end else if (bus_i.addr == `NVMC_OFS_DATA_HI) begin
                r_nxt.rdata = {2'h0, r_r.data[13:8]};
            end else if (bus_i.addr == `NVMC_OFS_CTRL) begin
                r_nxt.rdata = r_r.ctrl;
            end else if (bus_i.addr == `NVMC_OFS_IRQ_FLG) begin
                r_nxt.rdata = {7'h00, r_r.done_flag};
            end else if (bus_i.addr == `NVMC_OFS_IRQ_ENA) begin
                r_nxt.rdata = {7'h00, r_r.done_ie};
            end else begin
                r_nxt.rdata = `NVMC_RST_BYTE;
            end
        end

        // Read strobe: one array cycle, then cleared by hardware
        // The array must answer within that cycle
        if (rd_request) begin
            r_nxt.ctrl.rd = 1'b1;
            r_nxt.st      = NVMC_ST_READ;
            r_nxt.mem.req = 1'b1;
            r_nxt.mem.cmd = NVMC_CMD_READ;
        end

        // Write strobe: checked against key, enable and target
        // Any strobe uses up the key, refused or not, so a second
        // try needs a fresh unlock
        if (wr_request) begin
            r_nxt.key = NVMC_KEY_NONE;
            if (wr_allowed) begin
                r_nxt.ctrl.wr = 1'b1;
                r_nxt.mem.req = 1'b1;
                if (is_eeprom) begin
                    r_nxt.mem.cmd = NVMC_CMD_EEWR;
                    r_nxt.st      = NVMC_ST_BUSY;
                end else if (r_r.ctrl.erase) begin
                    r_nxt.mem.cmd = NVMC_CMD_ERASE;
                    r_nxt.st      = NVMC_ST_BUSY;
                    r_nxt.stall   = 1'b1;
                end else if (r_r.ctrl.latch_only) begin
                    r_nxt.mem.cmd = NVMC_CMD_LATCH;
                    r_nxt.st      = NVMC_ST_LATCH;
                    r_nxt.stall   = 1'b1;
                end else begin
                    r_nxt.mem.cmd = NVMC_CMD_PROG;
                    r_nxt.st      = NVMC_ST_BUSY;
                    r_nxt.stall   = 1'b1;
                end
            end else if (r_r.st == NVMC_ST_IDLE) begin
                // Refused strobe: nothing starts, strobe stays clear
                r_nxt.ctrl.err = 1'b1;
            end
        end

        // Address and data to the arrays follow the registers
        // Next values, so a request already carries a control or
        // address write made in the same cycle
        r_nxt.mem.flash = r_nxt.ctrl.flash;
        r_nxt.mem.cfg   = r_nxt.ctrl.cfg;
        r_nxt.mem.addr  = {r_nxt.addr_hi, r_nxt.addr_lo};
        r_nxt.mem.wdata = r_nxt.data;

        // Sequencer
        // Idle waits for a strobe; the others end alone or on the array
        case (r_r.st)
            NVMC_ST_IDLE: begin
                r_nxt.stall = r_nxt.stall;
            end
            NVMC_ST_READ: begin
                // Array answers in the cycle of the request
                // Data EEPROM words are one byte, high byte reads zero
                if (r_r.ctrl.cfg && !cfg_readable) begin
                    r_nxt.data = 14'h0000;
                end else if (is_eeprom) begin
                    r_nxt.data = {6'h00, mem_rdata_i[7:0]};
                end else begin
                    r_nxt.data = mem_rdata_i;
                end
                r_nxt.ctrl.rd = 1'b0;
                r_nxt.st      = NVMC_ST_IDLE;
                r_nxt.mem.cmd = NVMC_CMD_NONE;
            end
            NVMC_ST_LATCH: begin
                // Latch load is a single cycle, not self-timed
                // No done flag: only timed operations report it
                r_nxt.ctrl.wr = 1'b0;
                r_nxt.stall   = 1'b0;
                r_nxt.st      = NVMC_ST_IDLE;
                r_nxt.mem.cmd = NVMC_CMD_NONE;
            end
            NVMC_ST_BUSY: begin
                // Command and stall hold until the array reports
                if (op_done || op_abort) begin
                    r_nxt.ctrl.wr = 1'b0;
                    r_nxt.stall   = 1'b0;
                    r_nxt.st      = NVMC_ST_IDLE;
                    r_nxt.mem.cmd = NVMC_CMD_NONE;
                end
                if (op_done && r_r.mem.cmd == NVMC_CMD_ERASE) begin
                    r_nxt.ctrl.erase = 1'b0;
                end
                if (op_done) begin
                    r_nxt.done_flag = 1'b1;
                end
                if (op_abort) begin
                    r_nxt.ctrl.err = 1'b1;
                end
            end
            default: begin
                // A stray code recovers to idle
                r_nxt.st    = NVMC_ST_IDLE;
                r_nxt.stall = 1'b0;
            end
        endcase

        // Interrupt request from the sticky done flag
        // Registered from the next flag and enable, so it changes in the same cycle as they do
        r_nxt.irq = r_nxt.done_flag && r_nxt.done_ie;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    // Synchronous reset; every field gets its cleared value
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            r_r.st        <= NVMC_ST_IDLE;
            r_r.key       <= NVMC_KEY_NONE;
            r_r.ctrl      <= `NVMC_RST_BYTE;
            r_r.addr_lo   <= `NVMC_RST_BYTE;
            r_r.addr_hi   <= 7'h00;
            r_r.data      <= 14'h0000;
            r_r.done_flag <= 1'b0;
            r_r.done_ie   <= 1'b0;
            r_r.rdata     <= `NVMC_RST_BYTE;
            r_r.mem       <= '0;
            r_r.stall     <= 1'b0;
            r_r.irq       <= 1'b0;
        end else begin
            r_r <= r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from the state register
    // No logic between the record and the ports
    always_comb begin
        bus_rdata_o = r_r.rdata;
        mem_o       = r_r.mem;
        cpu_stall_o = r_r.stall;
        nvm_irq_o   = r_r.irq;
    end

endmodule
`default_nettype wire

// >>> verif/nvmc_chk_sva.sv
// Port checker for the nonvolatile memory controller
`timescale 1ns/1ps
`default_nettype none
`include "nvmc_params.svh"

module nvmc_chk
    import nvmc_pkg::*;
(
    input wire logic         clk_sys_i,
    input wire logic         reset_i,
    input wire nvmc_bus_type bus_i,
    input wire logic [7:0]   bus_rdata_o,
    input wire nvmc_mem_type mem_o,
    input wire logic         mem_done_i,
    input wire logic         mem_abort_i,
    input wire logic         cpu_stall_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    ////////////////////////////////////////////////////////////////////////
    // Bus decodes kept as plain wires so $past only ever sees a signal
    logic ctl_wr;
    logic key1_wr;
    logic key2_wr;
    logic busy;
    assign ctl_wr  = bus_i.wr && bus_i.addr == `NVMC_OFS_CTRL;
    assign key1_wr = bus_i.wr && bus_i.addr == `NVMC_OFS_KEY && bus_i.wdata == `NVMC_KEY_FIRST;
    assign key2_wr = bus_i.wr && bus_i.addr == `NVMC_OFS_KEY && bus_i.wdata == `NVMC_KEY_SECOND;
    assign busy    = mem_o.cmd inside {NVMC_CMD_PROG, NVMC_CMD_ERASE, NVMC_CMD_EEWR};

    // Read strobe set while the arrays are quiet, then a single request
    sequence rd_set_s;
        ctl_wr && bus_i.wdata[1:0] == 2'b01 && mem_o.cmd == NVMC_CMD_NONE;
    endsequence
    sequence rd_pulse_s;
        mem_o.req && mem_o.cmd == NVMC_CMD_READ ##1 !mem_o.req;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    read_pulse_a: assert property (rd_set_s |=> rd_pulse_s)
        else $error("read strobe did not give one read request");
    unlock_need_a: assert property (mem_o.req && mem_o.cmd != NVMC_CMD_READ |->
        $past(ctl_wr) && $past(key2_wr, 2) && $past(key1_wr, 3))
        else $error("array write started without the unlock pair");
    stall_hold_a: assert property (cpu_stall_o && mem_o.cmd != NVMC_CMD_LATCH
        && !mem_done_i && !mem_abort_i |=> cpu_stall_o)
        else $error("stall dropped before the array finished");
    done_release_a: assert property (busy && (mem_done_i || mem_abort_i) |=>
        mem_o.cmd == NVMC_CMD_NONE && !cpu_stall_o)
        else $error("operation did not end after completion");
    wr_busy_a: assert property (bus_i.rd && bus_i.addr == `NVMC_OFS_CTRL && busy
        && !mem_done_i && !mem_abort_i |=> bus_rdata_o[`NVMC_BIT_WR])
        else $error("write strobe read low while busy");
    ee_no_stall_a: assert property (mem_o.req && mem_o.cmd == NVMC_CMD_EEWR |->
        !mem_o.flash && !mem_o.cfg && !cpu_stall_o)
        else $error("data write in wrong space or stalling");
    flash_stall_a: assert property (mem_o.req && mem_o.cmd inside
        {NVMC_CMD_LATCH, NVMC_CMD_PROG, NVMC_CMD_ERASE} |-> cpu_stall_o && (mem_o.flash || mem_o.cfg))
        else $error("program space operation without stall");
    addr_pad_a: assert property (bus_i.rd && bus_i.addr == `NVMC_OFS_ADDR_HI |=> bus_rdata_o[7])
        else $error("address high top bit read low");
    key_read_a: assert property (bus_i.rd && bus_i.addr == `NVMC_OFS_KEY |=> bus_rdata_o == 8'h00)
        else $error("key register read nonzero");
endmodule

bind nvmc_ctrl nvmc_chk u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus_i(bus_i),
    .bus_rdata_o(bus_rdata_o), .mem_o(mem_o), .mem_done_i(mem_done_i),
    .mem_abort_i(mem_abort_i), .cpu_stall_o(cpu_stall_o));
`default_nettype wire

// >>> verif/nvmc_ctrl_tb.sv
// Self-checking testbench for the nonvolatile memory controller
`timescale 1ns/1ps
`default_nettype none
`include "nvmc_params.svh"

// Count each compare, report a mismatch at once
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); end end

module nvmc_ctrl_tb
    import nvmc_pkg::*;
();
    localparam logic [2:0] ctl = `NVMC_OFS_CTRL;
    localparam logic [2:0] key = `NVMC_OFS_KEY;
    localparam logic [2:0] flg = `NVMC_OFS_IRQ_FLG;
    logic         clk_sys_i   = 1'b0;
    logic         reset_i     = 1'b1;
    nvmc_bus_type bus_i       = '0;
    logic [7:0]   bus_rdata_o;
    nvmc_mem_type mem_o;
    logic [13:0]  mem_rdata_i = 14'h2ABC;
    logic         mem_done_i  = 1'b0;
    logic         mem_abort_i = 1'b0;
    logic         cpu_stall_o;
    logic         nvm_irq_o;
    int           fail_count  = 0;
    int           checks      = 0;

    nvmc_ctrl uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus_i(bus_i), .bus_rdata_o(bus_rdata_o),
        .mem_o(mem_o), .mem_rdata_i(mem_rdata_i), .mem_done_i(mem_done_i), .mem_abort_i(mem_abort_i),
        .cpu_stall_o(cpu_stall_o), .nvm_irq_o(nvm_irq_o));

    // 250 MHz system clock
    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write leaves its strobe up so unlock writes run back to back
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        bus_i <= {a, d, 1'b1, 1'b0};
    endtask
    task automatic idle();
        @(posedge clk_sys_i);
        bus_i <= '0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        bus_i <= {a, 8'h00, 1'b0, 1'b1};
        idle();
        `CHK(bus_rdata_o, e)
    endtask
    // Arm control, unlock if asked, strobe; request shows one cycle on
    task automatic op(input logic [7:0] c, input logic unl, input nvmc_cmd_type ce);
        wr(ctl, c & 8'hFD);
        if (unl) begin
            wr(key, `NVMC_KEY_FIRST);
            wr(key, `NVMC_KEY_SECOND);
        end
        wr(ctl, c);
        idle();
        `CHK(mem_o.req, ce != NVMC_CMD_NONE)
        `CHK(mem_o.cmd, ce)
    endtask
    // Array ends a short self-timed run, normally or by abort
    task automatic finish(input logic ab);
        repeat (3) @(posedge clk_sys_i);
        mem_done_i  <= ~ab;
        mem_abort_i <= ab;
        @(posedge clk_sys_i);
        mem_done_i  <= 1'b0;
        mem_abort_i <= 1'b0;
        #1;
        `CHK(cpu_stall_o, 1'b0)
        `CHK(mem_o.cmd, NVMC_CMD_NONE)
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(`NVMC_OFS_ADDR_LO, 8'h00);
        rd(`NVMC_OFS_ADDR_HI, 8'h80);
        rd(ctl, 8'h00);
        wr(`NVMC_OFS_ADDR_LO, 8'hA5);
        wr(`NVMC_OFS_ADDR_HI, 8'h7F);
        wr(key, 8'h3C);
        rd(`NVMC_OFS_ADDR_LO, 8'hA5);
        idle();
        `CHK(bus_rdata_o, 8'h00)
        rd(`NVMC_OFS_ADDR_HI, 8'hFF);
        rd(key, 8'h00);
        $display("registers test done");
    endtask
    task automatic t_read();
        wr(`NVMC_OFS_ADDR_LO, 8'h02);
        wr(`NVMC_OFS_ADDR_HI, 8'h00);
        wr(ctl, 8'h81);
        idle();
        `CHK(mem_o.cmd, NVMC_CMD_READ)
        `CHK(mem_o.flash, 1'b1)
        `CHK(mem_o.addr, 15'h0002)
        rd(ctl, 8'h80);
        rd(`NVMC_OFS_DATA_LO, 8'hBC);
        rd(`NVMC_OFS_DATA_HI, 8'h2A);
        wr(`NVMC_OFS_ADDR_LO, 8'h04);
        wr(ctl, 8'h41);
        idle();
        `CHK(mem_o.cfg, 1'b1)
        rd(`NVMC_OFS_DATA_LO, 8'h00);
        rd(`NVMC_OFS_DATA_HI, 8'h00);
        $display("read test done");
    endtask
    task automatic t_flash();
        wr(`NVMC_OFS_IRQ_ENA, 8'h01);
        wr(`NVMC_OFS_DATA_LO, 8'h5A);
        wr(`NVMC_OFS_DATA_HI, 8'hFF);
        rd(`NVMC_OFS_DATA_HI, 8'h3F);
        op(8'h86, 1'b1, NVMC_CMD_PROG);
        `CHK(cpu_stall_o, 1'b1)
        `CHK(mem_o.wdata, 14'h3F5A)
        `CHK(mem_o.addr, 15'h0004)
        wr(ctl, 8'h84);
        rd(ctl, 8'h86);
        finish(1'b0);
        `CHK(nvm_irq_o, 1'b1)
        rd(ctl, 8'h84);
        wr(flg, 8'h00);
        rd(flg, 8'h00);
        `CHK(nvm_irq_o, 1'b0)
        op(8'h96, 1'b1, NVMC_CMD_ERASE);
        finish(1'b0);
        rd(ctl, 8'h84);
        op(8'hA6, 1'b1, NVMC_CMD_LATCH);
        idle();
        `CHK(mem_o.cmd, NVMC_CMD_NONE)
        rd(ctl, 8'hA4);
        $display("flash test done");
    endtask
    task automatic t_eeprom();
        wr(`NVMC_OFS_IRQ_ENA, 8'h00);
        wr(flg, 8'h00);
        op(8'h36, 1'b1, NVMC_CMD_EEWR);
        `CHK(cpu_stall_o, 1'b0)
        finish(1'b0);
        `CHK(nvm_irq_o, 1'b0)
        rd(flg, 8'h01);
        wr(ctl, 8'h01);
        idle();
        `CHK(mem_o.flash, 1'b0)
        rd(`NVMC_OFS_DATA_HI, 8'h00);
        rd(`NVMC_OFS_DATA_LO, 8'hBC);
        $display("eeprom test done");
    endtask
    task automatic t_refuse();
        op(8'h86, 1'b0, NVMC_CMD_NONE);
        rd(ctl, 8'h8C);
        op(8'h82, 1'b1, NVMC_CMD_NONE);
        rd(ctl, 8'h88);
        op(8'h86, 1'b1, NVMC_CMD_PROG);
        finish(1'b1);
        rd(ctl, 8'h8C);
        wr(`NVMC_OFS_ADDR_LO, 8'h06);
        op(8'hC6, 1'b1, NVMC_CMD_NONE);
        wr(`NVMC_OFS_ADDR_LO, 8'h01);
        op(8'hC6, 1'b1, NVMC_CMD_PROG);
        finish(1'b0);
        $display("refusal test done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog well beyond the hundred-odd cycles the tests need
    initial begin
        #20000;
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        t_regs();
        t_read();
        t_flash();
        t_eeprom();
        t_refuse();
        complete_run();
    end
endmodule
`default_nettype wire
